// file: verilog/panel_output_pipeline.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Per-channel 8-in 10-out gamma table
// - Signed offset added, clamped to 0..3FFh
// - Offset spans +-127*4, no table reload
// - Ordered or random dither for 6-bit panels
// - Border inside enable region gets background colour
// - Horizontal enable and sync edges programmable
// - Vertical enable and sync edges programmable
// - Counts to 2048, horizontal 1024 two-pixel
// - Outputs change on panel clock rise
// - Sixteen 800 ps skew steps plus inversion
// - Each panel clock has own polarity
// - One or two pixels per panel clock
// - Pad drive 2 to 20 mA
// - Clock, data, control pads separately set
// - Off: powers low, interface forced low
// - Step one: logic power, interface low
// - Step two: logic power, interface driven
// - Full: both powers until enable clears
// - Each interval one to eight steps
// - Step is 511X or 32193X reference cycles
// - Down intervals use entries 3, 2, 1; up use 0, 1, 2
// - Drive code 0 tristate, 10-15 saturate
module panel_output_pipeline #(
  parameter int STEP_SHORT_CYC = panel_pkg::STEP_SHORT,
  parameter int STEP_LONG_CYC = panel_pkg::STEP_LONG
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic panel_link_clk,
  input wire panel_pkg::chan8_t pixel_in,
  input wire logic pixel_in_valid,
  output logic pixel_in_ready,
  input wire logic lut_wr_en,
  input wire logic [1:0] lut_wr_chan,
  input wire logic [7:0] lut_wr_addr,
  input wire logic [9:0] lut_wr_data,
  input wire logic [2:0][9:0] chan_offset,
  input wire logic dither_en,
  input wire logic dither_random,
  input wire panel_pkg::chan8_t bg_color,
  input wire logic two_pixel_mode,
  input wire panel_pkg::axis_timing_s h_timing,
  input wire panel_pkg::axis_timing_s v_timing,
  input wire panel_pkg::window_s image_win,
  input wire logic clk_invert_a,
  input wire logic clk_invert_b,
  input wire logic [3:0] clk_skew_code,
  input wire panel_pkg::drive_s pad_drive,
  input wire logic panel_enable_ctl,
  input wire logic protect_trip,
  input wire logic [3:0][2:0] seq_interval,
  input wire logic seq_step_long,
  input wire logic [7:0] seq_step_mult,
  output logic panel_vert_sync_q,
  output logic panel_horiz_sync_q,
  output logic panel_display_enable_q,
  output panel_pkg::pix_pair_s panel_data_q,
  output logic panel_clock_a_q,
  output logic panel_clock_b_q,
  output logic [3:0] panel_clk_skew_q,
  output logic panel_logic_power_q,
  output logic panel_bias_power_q,
  output logic pad_clk_oe_q,
  output logic pad_data_oe_q,
  output logic pad_ctl_oe_q,
  output panel_pkg::drive_s pad_drive_level_q,
  output logic [1:0] power_state_q
);
  function automatic logic in_span(input logic [10:0] c, input logic [10:0] s, input logic [10:0] e);
    return (c >= s) && (c < e);
  endfunction

  function automatic logic [3:0] drive_level(input logic [3:0] code);
    return (code > panel_pkg::DRIVE_SAT_CODE) ? panel_pkg::DRIVE_SAT_LEVEL : code;
  endfunction

  function automatic logic [9:0] clamp_offset(input logic [9:0] o);
    if ($signed(o) > panel_pkg::OFFSET_MAX) begin
      return panel_pkg::OFFSET_MAX;
    end else if ($signed(o) < -panel_pkg::OFFSET_MAX) begin
      return -panel_pkg::OFFSET_MAX;
    end
    return o;
  endfunction

  // The panel clock is only sampled; clk_s1_q feeds nothing but clk_s2_q
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      clk_s1_q <= panel_link_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end
  wire logic pix_tick = clk_s2_q & ~clk_s3_q;

  panel_pkg::pwr_state_e seq_state;
  logic seq_power, seq_bias, seq_active;
  power_sequencer #(
    .STEP_SHORT_CYC(STEP_SHORT_CYC),
    .STEP_LONG_CYC(STEP_LONG_CYC)
  ) u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(panel_enable_ctl & ~protect_trip),
    .interval(seq_interval),
    .step_long(seq_step_long),
    .step_mult(seq_step_mult),
    .state(seq_state),
    .logic_power(seq_power),
    .bias_power(seq_bias),
    .iface_active(seq_active)
  );

  logic [10:0] h_q, v_q;
  // Two pixels per clock halves the horizontal count range
  wire logic [10:0] h_last = (two_pixel_mode && h_timing.total > panel_pkg::H_TWO_PIX_LAST) ?
                             panel_pkg::H_TWO_PIX_LAST : h_timing.total;
  wire logic h_wrap = h_q >= h_last;
  wire logic v_wrap = v_q >= v_timing.total;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= '0;
      v_q <= '0;
    end else if (pix_tick) begin
      h_q <= h_wrap ? 11'h000 : h_q + 11'h001;
      if (h_wrap) begin
        v_q <= v_wrap ? 11'h000 : v_q + 11'h001;
      end
    end
  end

  wire logic h_de = in_span(h_q, h_timing.de_start, h_timing.de_end);
  wire logic v_de = in_span(v_q, v_timing.de_start, v_timing.de_end);
  wire logic hs = in_span(h_q, h_timing.sync_start, h_timing.sync_end);
  wire logic vs = in_span(v_q, v_timing.sync_start, v_timing.sync_end);
  wire logic de = h_de & v_de;
  wire logic img = in_span(h_q, image_win.h_start, image_win.h_end) &
                   in_span(v_q, image_win.v_start, image_win.v_end);

  panel_pkg::chan8_t stash_q;
  logic stash_full_q;
  logic buf_in_ready, buf_out_valid;
  panel_pkg::pix_pair_s buf_out;
  wire logic first_half = two_pixel_mode & ~stash_full_q;
  wire logic push_valid = pixel_in_valid & ~first_half;
  wire panel_pkg::pix_pair_s push_word = two_pixel_mode ? {pixel_in, stash_q} : {24'h000000, pixel_in};
  wire logic want_pix = pix_tick & seq_active & de & img;
  assign pixel_in_ready = first_half | buf_in_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stash_q <= '0;
      stash_full_q <= 1'b0;
    end else if (pixel_in_valid && first_half) begin
      stash_q <= pixel_in;
      stash_full_q <= 1'b1;
    end else if (push_valid && buf_in_ready) begin
      stash_full_q <= 1'b0;
    end
  end

  pixel_buffer #(
    .W($bits(panel_pkg::pix_pair_s)),
    .DEPTH(panel_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data(push_word),
    .out_valid(buf_out_valid),
    .out_ready(want_pix),
    .out_data(buf_out)
  );

  // Table writes land at once; offsets act after the table so brightness needs no reload
  logic [9:0] lut_q [panel_pkg::NUM_CHAN][panel_pkg::LUT_DEPTH];
  always_ff @(posedge core_clk) begin
    if (lut_wr_en && lut_wr_chan < 2'(panel_pkg::NUM_CHAN)) begin
      lut_q[lut_wr_chan][lut_wr_addr] <= lut_wr_data;
    end
  end

  logic [15:0] lfsr_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= panel_pkg::LFSR_SEED;
    end else if (pix_tick) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  logic [2:0][9:0] offs;
  logic [1:0][2:0][7:0] head_lanes, proc_lanes;
  assign head_lanes = buf_out;
  genvar l, c;
  generate
    for (c = 0; c < panel_pkg::NUM_CHAN; c++) begin : g_ofs
      assign offs[c] = clamp_offset(chan_offset[c]);
    end
    for (l = 0; l < 2; l++) begin : g_lane
      for (c = 0; c < panel_pkg::NUM_CHAN; c++) begin : g_ch
        wire logic [9:0] gam = lut_q[c][head_lanes[l][c]];
        wire logic signed [11:0] sum = $signed({2'b00, gam}) + $signed({{2{offs[c][9]}}, offs[c]});
        wire logic [9:0] cl = sum[11] ? 10'h000 : (sum[10] ? 10'h3ff : sum[9:0]);
        wire logic hb = two_pixel_mode ? 1'(l) : h_q[0];
        wire logic [3:0] thr = dither_random ? lfsr_q[l*4 +: 4] : {hb ^ v_q[0], v_q[0], 2'b10};
        wire logic up = (cl[3:0] > thr) && (cl[9:4] != 6'h3f);
        assign proc_lanes[l][c] = dither_en ? {cl[9:4] + {5'h00, up}, 2'b00} : cl[9:2];

        property p_clamp_low;
          @(posedge core_clk) disable iff (!rst_n) !dither_en && sum < 0 |-> proc_lanes[l][c] == 8'h00;
        endproperty
        a_clamp_low: assert property (p_clamp_low) else $error("negative sum not clamped");
      end
    end
  endgenerate

  wire logic [47:0] proc_word = two_pixel_mode ? proc_lanes : {24'h000000, proc_lanes[0]};
  wire logic [47:0] fill_word = two_pixel_mode ? {bg_color, bg_color} : {24'h000000, bg_color};
  wire logic [47:0] data_d = (img && buf_out_valid) ? proc_word : fill_word;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_vert_sync_q <= 1'b0;
      panel_horiz_sync_q <= 1'b0;
      panel_display_enable_q <= 1'b0;
      panel_data_q <= '0;
      panel_clock_a_q <= 1'b0;
      panel_clock_b_q <= 1'b0;
    end else if (!seq_active) begin
      panel_vert_sync_q <= 1'b0;
      panel_horiz_sync_q <= 1'b0;
      panel_display_enable_q <= 1'b0;
      panel_data_q <= '0;
      panel_clock_a_q <= 1'b0;
      panel_clock_b_q <= 1'b0;
    end else begin
      panel_clock_a_q <= clk_s2_q ^ clk_invert_a;
      panel_clock_b_q <= clk_s2_q ^ clk_invert_b;
      if (pix_tick) begin
        panel_vert_sync_q <= vs;
        panel_horiz_sync_q <= hs;
        panel_display_enable_q <= de;
        panel_data_q <= de ? data_d : 48'h0;
      end
    end
  end

  // Sub-cycle skew cannot be built from core_clk, so the code goes to the pad delay line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_clk_skew_q <= '0;
      panel_logic_power_q <= 1'b0;
      panel_bias_power_q <= 1'b0;
      pad_clk_oe_q <= 1'b0;
      pad_data_oe_q <= 1'b0;
      pad_ctl_oe_q <= 1'b0;
      pad_drive_level_q <= '0;
      power_state_q <= '0;
    end else begin
      panel_clk_skew_q <= clk_skew_code;
      panel_logic_power_q <= seq_power;
      panel_bias_power_q <= seq_bias;
      pad_clk_oe_q <= pad_drive.clk != panel_pkg::DRIVE_TRISTATE;
      pad_data_oe_q <= pad_drive.data != panel_pkg::DRIVE_TRISTATE;
      pad_ctl_oe_q <= pad_drive.ctl != panel_pkg::DRIVE_TRISTATE;
      pad_drive_level_q <= {drive_level(pad_drive.clk), drive_level(pad_drive.data),
                            drive_level(pad_drive.ctl)};
      power_state_q <= seq_state;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_quiet_off;
    !seq_active |=> panel_data_q == '0 && !panel_display_enable_q && !panel_clock_a_q && !panel_clock_b_q;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("panel driven while inactive");

  property p_change_on_tick;
    seq_active && $past(seq_active) && $changed(panel_data_q) |-> $past(pix_tick);
  endproperty
  a_change_on_tick: assert property (p_change_on_tick) else $error("data changed off clock edge");

  property p_de_window;
    pix_tick && seq_active |=> panel_display_enable_q == $past(h_de && v_de);
  endproperty
  a_de_window: assert property (p_de_window) else $error("enable outside windows");

  property p_bg_fill;
    pix_tick && seq_active && de && !img |=> panel_data_q.p0 == $past(bg_color);
  endproperty
  a_bg_fill: assert property (p_bg_fill) else $error("border not background colour");

  property p_bias_power;
    panel_bias_power_q |-> panel_logic_power_q ##1 panel_logic_power_q || !panel_bias_power_q;
  endproperty
  a_bias_power: assert property (p_bias_power) else $error("bias without logic power");

  property p_tristate;
    pad_drive.data == panel_pkg::DRIVE_TRISTATE |=> !pad_data_oe_q && pad_drive_level_q.data == 4'h0;
  endproperty
  a_tristate: assert property (p_tristate) else $error("code zero still drives");

  c_two_pix_pop: cover property (two_pixel_mode && want_pix && buf_out_valid);
  c_border: cover property (pix_tick && seq_active && de && !img);
  c_stall: cover property (pixel_in_valid && !pixel_in_ready);
endmodule // panel_output_pipeline

// file: verilog/panel_pkg.sv
package panel_pkg;
  localparam int CNT_W = 11;
  localparam int GAMMA_W = 10;
  localparam int LUT_DEPTH = 256;
  localparam int NUM_CHAN = 3;
  localparam int BUF_DEPTH = 2;
  localparam int STEP_SHORT = 511;
  localparam int STEP_LONG = 32193;
  localparam int STEP_MULT_MAX = 256;
  localparam int SKEW_STEP_PS = 800;
  localparam int SKEW_STEPS = 16;
  localparam logic signed [9:0] OFFSET_MAX = 10'sd508;
  localparam logic [10:0] H_TWO_PIX_LAST = 11'h3ff;
  localparam logic [3:0] DRIVE_SAT_CODE = 4'h9;
  localparam logic [3:0] DRIVE_SAT_LEVEL = 4'ha;
  localparam logic [3:0] DRIVE_TRISTATE = 4'h0;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef logic [2:0][7:0] chan8_t;

  typedef struct packed {
    chan8_t p1;
    chan8_t p0;
  } pix_pair_s;

  typedef struct packed {
    logic [10:0] total;
    logic [10:0] de_start;
    logic [10:0] de_end;
    logic [10:0] sync_start;
    logic [10:0] sync_end;
  } axis_timing_s;

  typedef struct packed {
    logic [10:0] h_start;
    logic [10:0] h_end;
    logic [10:0] v_start;
    logic [10:0] v_end;
  } window_s;

  typedef struct packed {
    logic [3:0] clk;
    logic [3:0] data;
    logic [3:0] ctl;
  } drive_s;

  typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_DRIVE, PWR_FULL} pwr_state_e;
endpackage

// file: verilog/pixel_buffer.sv
`timescale 1ns/1ps
module pixel_buffer #(
  parameter int W = 48,
  parameter int DEPTH = panel_pkg::BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = cnt_q < (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // pixel_buffer

// file: verilog/power_sequencer.sv
`timescale 1ns/1ps
module power_sequencer #(
  parameter int STEP_SHORT_CYC = panel_pkg::STEP_SHORT,
  parameter int STEP_LONG_CYC = panel_pkg::STEP_LONG
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0][2:0] interval,
  input wire logic step_long,
  input wire logic [7:0] step_mult,
  output panel_pkg::pwr_state_e state,
  output logic logic_power,
  output logic bias_power,
  output logic iface_active
);
  panel_pkg::pwr_state_e state_q, state_d;
  logic [15:0] base_q;
  logic [7:0] mult_q;
  logic [2:0] steps_q;
  logic dir_q;
  wire logic [1:0] st = state_q;
  // The interval index equals the state code in both directions, so down steps use entries 3, 2, 1 and up steps 0, 1, 2
  wire logic [2:0] cur_len = interval[st];
  wire logic moving = enable ? (state_q != panel_pkg::PWR_FULL) : (state_q != panel_pkg::PWR_OFF);
  wire logic [15:0] base_last = step_long ? 16'(STEP_LONG_CYC - 1) : 16'(STEP_SHORT_CYC - 1);
  wire logic base_end = base_q == base_last;
  wire logic mult_end = mult_q == step_mult;
  wire logic step_end = moving & (dir_q == enable) & base_end & mult_end & (steps_q == cur_len);

  always_comb begin
    state_d = state_q;
    if (step_end) begin
      case (state_q)
        panel_pkg::PWR_OFF: state_d = panel_pkg::PWR_ON;
        panel_pkg::PWR_ON: state_d = enable ? panel_pkg::PWR_DRIVE : panel_pkg::PWR_OFF;
        panel_pkg::PWR_DRIVE: state_d = enable ? panel_pkg::PWR_FULL : panel_pkg::PWR_ON;
        panel_pkg::PWR_FULL: state_d = panel_pkg::PWR_DRIVE;
        default: state_d = panel_pkg::PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= panel_pkg::PWR_OFF;
      base_q <= '0;
      mult_q <= '0;
      steps_q <= '0;
      dir_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dir_q <= enable;
      // A reversal mid-interval restarts the wait so no step is ever cut short
      if (!moving || dir_q != enable || step_end) begin
        base_q <= '0;
        mult_q <= '0;
        steps_q <= '0;
      end else if (!base_end) begin
        base_q <= base_q + 16'h0001;
      end else begin
        base_q <= '0;
        mult_q <= mult_end ? 8'h00 : mult_q + 8'h01;
        if (mult_end) begin
          steps_q <= steps_q + 3'h1;
        end
      end
    end
  end

  assign state = state_q;
  assign logic_power = state_q != panel_pkg::PWR_OFF;
  assign bias_power = state_q == panel_pkg::PWR_FULL;
  assign iface_active = state_q == panel_pkg::PWR_DRIVE || state_q == panel_pkg::PWR_FULL;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_seq_adjacent;
    $changed(state_q) |-> (2'(st - $past(st)) == 2'h1) || (2'($past(st) - st) == 2'h1);
  endproperty
  a_seq_adjacent: assert property (p_seq_adjacent) else $error("sequencer skipped a state");

  property p_seq_waits;
    $changed(state_q) |-> $past(step_end) && $past(steps_q) == $past(cur_len);
  endproperty
  a_seq_waits: assert property (p_seq_waits) else $error("state moved before its interval");

  property p_off_holds;
    (state_q == panel_pkg::PWR_OFF) && !enable |=> state_q == panel_pkg::PWR_OFF;
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("left power off while disabled");

  property p_full_holds;
    (state_q == panel_pkg::PWR_FULL) && enable |=> state_q == panel_pkg::PWR_FULL;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("left full state while enabled");

  c_reach_full: cover property (state_q == panel_pkg::PWR_DRIVE ##1 state_q == panel_pkg::PWR_FULL);
  c_back_off: cover property (state_q == panel_pkg::PWR_ON && !enable ##1 state_q == panel_pkg::PWR_OFF);
endmodule // power_sequencer

// file: dv/panel_model.sv
`timescale 1ns/1ps
module panel_model (
  input wire logic core_clk,
  input wire logic logic_power,
  input wire logic bias_power,
  output logic link_clk,
  output logic order_bad
);
  // Shift clock runs free at eight core periods; the odd start offset keeps its edges off the core clock edges
  initial begin
    link_clk = 1'b0;
    order_bad = 1'b0;
    #137;
    forever #400 link_clk = ~link_clk;
  end
  // Bias without logic power would damage a real panel
  always @(posedge core_clk) begin
    if (bias_power === 1'b1 && logic_power !== 1'b1) order_bad <= 1'b1;
  end
endmodule // panel_model

// file: dv/panel_output_pipeline_tb_top.sv
`timescale 1ns/1ps
module panel_output_pipeline_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lnk, bad, pixel_in_valid, pixel_in_ready, lut_wr_en, protect_trip, seq_step_long, en, feed, take;
  logic vs, hs, de, ca, cb, lp, bp, a_prev, vs_prev, hs_prev, de_prev;
  logic seen = 1'b0;
  logic rdy_low = 1'b0;
  logic dith = 1'b0;
  logic invb, dith_s, invb_s;
  logic [1:0] lut_wr_chan, st;
  logic [7:0] lut_wr_addr, seq_step_mult;
  logic [9:0] lut_wr_data;
  logic [2:0][9:0] chan_offset;
  logic [3:0] skew, skq;
  logic [2:0] oe;
  logic [3:0][2:0] ival;
  logic [15:0] r = 16'hb106;
  logic [15:0] pr = 16'hb106;
  panel_pkg::chan8_t pixel_in, bg, px, e;
  panel_pkg::drive_s drv, lvl;
  panel_pkg::pix_pair_s dq;
  panel_pkg::axis_timing_s ht = {11'h9, 11'h2, 11'h8, 11'h0, 11'h2};
  panel_pkg::axis_timing_s vt = {11'h5, 11'h2, 11'h5, 11'h0, 11'h1};
  panel_pkg::window_s win = {11'h3, 11'h6, 11'h3, 11'h5};
  int fails = 0;
  int n_compared = 0;
  int pos = 0;
  int row = 0;
  int hcnt = 0;
  int cnt, dthr, lut[3][256], off[3];
  panel_pkg::chan8_t q[$];

  always #50 core_clk = ~core_clk;

  panel_model panel_model_inst (.core_clk(core_clk), .logic_power(lp), .bias_power(bp), .link_clk(lnk),
    .order_bad(bad));

  panel_output_pipeline #(.STEP_SHORT_CYC(3), .STEP_LONG_CYC(5)) panel_output_pipeline_inst (
    .core_clk(core_clk), .rst_n(rst_n), .panel_link_clk(lnk), .pixel_in(pixel_in), .pixel_in_valid(pixel_in_valid),
    .pixel_in_ready(pixel_in_ready), .lut_wr_en(lut_wr_en), .lut_wr_chan(lut_wr_chan), .lut_wr_addr(lut_wr_addr),
    .lut_wr_data(lut_wr_data), .chan_offset(chan_offset), .dither_en(dith), .dither_random(1'b0), .bg_color(bg),
    .two_pixel_mode(1'b0), .h_timing(ht), .v_timing(vt), .image_win(win), .clk_invert_a(1'b0), .clk_invert_b(invb),
    .clk_skew_code(skew), .pad_drive(drv), .panel_enable_ctl(en), .protect_trip(protect_trip), .seq_interval(ival),
    .seq_step_long(seq_step_long), .seq_step_mult(seq_step_mult), .panel_vert_sync_q(vs), .panel_horiz_sync_q(hs),
    .panel_display_enable_q(de), .panel_data_q(dq), .panel_clock_a_q(ca), .panel_clock_b_q(cb),
    .panel_clk_skew_q(skq), .panel_logic_power_q(lp), .panel_bias_power_q(bp), .pad_clk_oe_q(oe[2]),
    .pad_data_oe_q(oe[1]), .pad_ctl_oe_q(oe[0]), .pad_drive_level_q(lvl), .power_state_q(st));

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] gam(input int c, input int v, input int thr);
    int t;
    t = lut[c][v] + off[c];
    t = t < 0 ? 0 : (t > 1023 ? 1023 : t);
    // Negative threshold selects plain truncation
    if (thr < 0) return t[9:2];
    if (t % 16 > thr && t / 16 < 63) t = t + 16;
    return {t[9:4], 2'b00};
  endfunction

  function automatic logic [3:0] lv(input int c);
    return c > 9 ? 4'ha : c[3:0];
  endfunction

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Waits for the next power state and checks how long the interval lasted
  task automatic go(input logic [1:0] s, input int exp);
    while (st !== s && cnt < 3000) begin
      tick;
      cnt++;
    end
    chk(cnt >= exp - 1 && cnt <= exp + 2, 1);
    tick;
    tick;
    cnt = 2;
    chk({lp, bp}, {s != 0, s == 3});
    if (s < 2) chk({vs, hs, de, ca, dq}, 0);
  endtask

  // Only accepted words enter the reference queue, so a refusal loses nothing
  always @(negedge core_clk) take = pixel_in_valid & pixel_in_ready;
  always @(posedge core_clk) begin
    // Controls as the design saw them at this edge
    {dith_s, invb_s} = {dith, invb};
    if (take === 1'b1) q.push_back(pixel_in);
    #1;
    if (take === 1'b1) begin
      pr = nx(pr);
      pixel_in <= {pr[7:0], pr[15:8], pr[12:5]};
    end
    pixel_in_valid <= feed & seen;
  end

  // Positions are rebuilt from the sync and enable edges seen at each panel clock rise
  always @(negedge core_clk) begin
    if (pixel_in_ready === 1'b0) rdy_low = 1'b1;
    if (st === 2'd3) chk(cb, ca ^ invb_s);
    if (ca === 1'b1 && a_prev === 1'b0) begin
      if (seen && hs_prev && !hs) chk(hcnt, 2);
      hcnt = hs ? hcnt + 1 : 0;
      if (vs && !vs_prev) begin
        if (seen) chk(row, 3);
        row = 0;
        seen = 1'b1;
      end
      if (de) begin
        e = bg;
        if (pos >= 1 && pos < 4 && row >= 1 && row < 3 && q.size() > 0) begin
          px = q.pop_front();
          // Enable windows start on even counts, so pos and row carry the counters' parity
          dthr = dith_s ? ((pos ^ row) % 2) * 8 + (row % 2) * 4 + 2 : -1;
          for (int c = 0; c < 3; c++) e[c] = gam(c, px[c], dthr);
        end
        if (seen) chk(dq, {24'h0, e});
        pos++;
      end else if (de_prev) begin
        if (seen) chk(pos, 6);
        pos = 0;
        row++;
      end
      {vs_prev, hs_prev, de_prev} = {vs, hs, de};
    end
    a_prev = ca;
  end

  initial begin
    #2000000;
    fails++;
    summarize;
  end

  initial begin
    {pixel_in_valid, lut_wr_en, protect_trip, seq_step_long, en, feed} = 6'h0;
    {lut_wr_chan, lut_wr_addr, lut_wr_data, drv} = 32'h0;
    pixel_in = 24'h0;
    off[2] = 508;
    off[1] = -508;
    off[0] = int'(r[7:0]) - 128;
    for (int c = 0; c < 3; c++) chan_offset[c] = off[c][9:0];
    bg = {r[7:0], r[15:8], 8'h3c};
    skew = r[3:0];
    invb = r[4];
    ival = r[11:0];
    seq_step_mult = 8'h01;
    repeat (3) @(posedge core_clk);
    chk({vs, hs, de, ca, cb, dq, lp, bp, st}, 0);
    #1;
    rst_n = 1'b1;
    for (int c = 0; c < 16; c++) begin
      drv = {c[3:0], 4'(15 - c), 4'(c + 5)};
      tick;
      tick;
      chk({lvl, oe}, {lv(c), lv(15 - c), lv((c + 5) % 16), c != 0, c != 15, (c + 5) % 16 != 0});
    end
    lut_wr_en = 1'b1;
    for (int c = 0; c < 3; c++) begin
      for (int a = 0; a < 256; a++) begin
        r = nx(r);
        lut_wr_chan = c[1:0];
        lut_wr_addr = a[7:0];
        lut_wr_data = r[9:0];
        lut[c][a] = r[9:0];
        tick;
      end
    end
    lut_wr_en = 1'b0;
    cnt = 0;
    en = 1'b1;
    go(2'd1, (ival[0] + 1) * 6);
    go(2'd2, (ival[1] + 1) * 6);
    go(2'd3, (ival[2] + 1) * 6);
    chk(skq, skew);
    feed = 1'b1;
    repeat (1000) tick;
    // Switch while pixels flow so the dithered path meets live data
    {dith, invb} = {1'b1, ~invb};
    repeat (1000) tick;
    chk(rdy_low, 1);
    feed = 1'b0;
    repeat (600) tick;
    chk(q.size(), 0);
    seq_step_long = 1'b1;
    protect_trip = 1'b1;
    cnt = 0;
    go(2'd2, (ival[3] + 1) * 10);
    go(2'd1, (ival[2] + 1) * 10);
    go(2'd0, (ival[1] + 1) * 10);
    repeat (40) tick;
    chk({st, bad}, 0);
    summarize;
  end
endmodule // panel_output_pipeline_tb_top
